// >>> fpd_pkg.sv
`default_nettype none
package fpd_pkg;
  // Core clock rate
  localparam int CLK_MHZ = 40;
  localparam int NS_PER_US = 1000;
  // Longest power_down_entry_time and power_down_exit_time, in ns
  localparam int ENTRY_TIME_NS = 1000;
  localparam int EXIT_TIME_NS = 3000;
  // Longest times round down, never below one cycle
  localparam int ENTRY_CYC_RAW = ENTRY_TIME_NS * CLK_MHZ / NS_PER_US;
  localparam int EXIT_CYC_RAW = EXIT_TIME_NS * CLK_MHZ / NS_PER_US;
  localparam int ENTRY_CYC = (ENTRY_CYC_RAW < 1) ? 1 : ENTRY_CYC_RAW;
  localparam int EXIT_CYC = (EXIT_CYC_RAW < 1) ? 1 : EXIT_CYC_RAW;
  localparam int TMR_W = 8;
  // Cycles lost between a chip-select rise and the timer load, plus the
  // final register; timers are loaded short by this many cycles
  localparam int EDGE_LAT_CYC = 4;
  localparam int ENTRY_LOAD = (ENTRY_CYC > EDGE_LAT_CYC) ?
                              ENTRY_CYC - EDGE_LAT_CYC : 1;
  localparam int EXIT_LOAD = (EXIT_CYC > EDGE_LAT_CYC) ?
                             EXIT_CYC - EDGE_LAT_CYC : 1;
  // Opcodes
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_RESUME = 8'hab;
  // Byte framing
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] BIT_FIRST = 3'h0;
  localparam logic [CNT_W-1:0] BIT_LAST = 3'h7;
  // Widths of crossing groups
  localparam int PIN_SYNC_W = 3;
  localparam logic [PIN_SYNC_W-1:0] PIN_IDLE = 3'h7;
  localparam int LINK_SYNC_W = 2 * BYTE_W + 3;
  // Power states
  typedef enum logic [3:0] {
    PWR_STANDBY = 4'h1,
    PWR_ENTER   = 4'h2,
    PWR_DOWN    = 4'h4,
    PWR_EXIT    = 4'h8
  } fpd_pwr_type;
endpackage
`default_nettype wire

// >>> fpd_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fpd_timer_if;
  logic start;
  logic run;
  logic done;
  modport owner (output start, input run, input done);
  modport timer (input start, output run, output done);
endinterface
`default_nettype wire

// >>> fpd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fpd_sync_type;
  fpd_sync_type q;
  fpd_sync_type d;

  // Two stages; only the second is seen outside
  always_comb begin
    d.s1 = d_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= {RST, RST};
    end else begin
      q <= d;
    end
  end

  assign q_o = q.s2;
endmodule
`default_nettype wire

// >>> fpd_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_timer
  import fpd_pkg::*;
#(
  parameter logic [TMR_W-1:0] LOAD = 8'h01
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  fpd_timer_if.timer t
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             done;
  } fpd_timer_type;
  fpd_timer_type q;
  fpd_timer_type d;

  // Count down from the load value, pulse done on reaching zero
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (t.start) begin
      d.cnt = LOAD;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
      d.done = (q.cnt == 8'h01);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign t.run = (q.cnt != '0);
  assign t.done = q.done;
endmodule
`default_nettype wire

// >>> fpd_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - In deep power-down every command is dropped except resume.
// - Opcode b9h then a clean chip-select rise enters power-down in time.
// - A short or misaligned power-down frame leaves the part in standby.
// - Reset always brings the part up in standby.
// - Power-down is ignored while a program or erase is busy.
// - Opcode abh then a clean chip-select rise returns to standby in time.
// - A short or misaligned resume frame leaves the part powered down.
// - Pausing the link never touches a running program or erase.
// - Pause starts only inside a frame with pause low in a clock low phase.
// - Pause raised in a clock high phase waits for the next low phase.
// - While paused output floats, input and clock are ignored, protect works.
// - Pause ends on release in a low phase, or at the next low phase.
// - Chip select released while paused aborts and clears the enable latch.
// - Output bits launch on the falling clock edge, inputs sample on rising.
module fpd_ctrl
  import fpd_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic              sck_i,
  input  wire logic              cs_n_i,
  input  wire logic              si_i,
  input  wire logic              hold_n_i,
  input  wire logic              wp_n_i,
  input  wire logic              busy_i,
  input  wire logic              wel_set_i,
  input  wire logic              wel_clr_i,
  input  wire logic [BYTE_W-1:0] tx_byte_i,
  input  wire logic              tx_en_i,
  output logic                   so_o,
  output logic                   so_oe_o,
  output logic [BYTE_W-1:0]      rx_byte_o,
  output logic                   rx_valid_o,
  output logic                   frame_abort_o,
  output logic                   write_enable_latch_o,
  output logic                   write_protect_o,
  output logic                   standby_o,
  output logic                   power_down_o
);

  // Link side, clocked by the serial clock. That clock may stop between
  // frames, so nothing here waits for an edge once chip select is high.
  // The core reads these registers only through two-stage synchronisers
  // and only after they have stood still for a whole byte or frame.

  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic [BYTE_W-1:0] shreg;
    logic [BYTE_W-1:0] opcode;
    logic              op_seen;
    logic              aligned;
    logic [BYTE_W-1:0] byte_q;
    logic              tog;
  } fpd_link_type;

  typedef struct packed {
    logic so;
  } fpd_out_type;

  fpd_link_type      lk_q;
  fpd_link_type      lk_d;
  fpd_out_type       ou_q;
  fpd_out_type       ou_d;
  logic              new_q;
  logic              frame_idle;
  logic [BYTE_W-1:0] tx_s;

  // Frame idle forces the next sampled bit to be bit zero
  assign frame_idle = cs_n_i | ~resetn_i;

  // Outgoing byte is held steady by the source; two stages on link clock
  // A byte changed in mid-frame may be seen half old and half new
  fpd_sync #(
    .W   (BYTE_W),
    .RST ('0)
  ) u_tx_sync (
    .clk_i    (sck_i),
    .resetn_i (resetn_i),
    .d_i      (tx_byte_i),
    .q_o      (tx_s)
  );

  // Marks the first bit of a frame; cleared only by a shifted bit
  // Chip select high sets it at once, so every frame starts at bit zero
  always_ff @(posedge sck_i or posedge frame_idle) begin
    if (frame_idle) begin
      new_q <= 1'b1;
    end else if (hold_n_i) begin
      new_q <= 1'b0;
    end
  end

  // Input shifter; hold level at the rising edge is the low-phase level
  always_comb begin
    logic [CNT_W-1:0]  cnt_base;
    logic              seen_base;
    logic [BYTE_W-1:0] full;
    cnt_base = new_q ? BIT_FIRST : lk_q.cnt;
    seen_base = new_q ? 1'b0 : lk_q.op_seen;
    full = {lk_q.shreg[BYTE_W-2:0], si_i};
    lk_d = lk_q;
    if (hold_n_i) begin
      lk_d.shreg = full;
      lk_d.cnt = cnt_base + 1'b1;
      lk_d.op_seen = seen_base;
      lk_d.aligned = 1'b0;
      if (cnt_base == BIT_LAST) begin
        lk_d.byte_q = full;
        lk_d.tog = ~lk_q.tog;
        lk_d.op_seen = 1'b1;
        lk_d.aligned = 1'b1;
        if (!seen_base) begin
          lk_d.opcode = full;
        end
      end
    end
  end

  always_ff @(posedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // Output bit launched on the falling edge, frozen while paused
  // Index follows the bits taken so far, so a new byte starts on the
  // falling edge right after the last bit of the byte before it
  always_comb begin
    logic [CNT_W-1:0] idx;
    idx = new_q ? BIT_FIRST : lk_q.cnt;
    ou_d = ou_q;
    if (hold_n_i && !cs_n_i) begin
      ou_d.so = tx_s[BIT_LAST - idx];
    end
  end

  always_ff @(negedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ou_q <= '0;
    end else begin
      ou_q <= ou_d;
    end
  end

  assign so_o = ou_q.so;

  // Core side, clocked by clk_i. Power decisions are taken only here,
  // once the end of a frame has come through the pin synchroniser.

  typedef struct packed {
    fpd_pwr_type       pwr;
    logic              cs_prev;
    logic              tog_prev;
    logic [BYTE_W-1:0] rx_byte;
    logic              rx_valid;
    logic              abort;
    logic              write_enable_latch;
    logic              wprot;
    logic              so_oe;
    logic              standby;
    logic              pd;
    logic              byte_in;
  } fpd_core_type;

  fpd_core_type           q;
  fpd_core_type           d;
  logic [PIN_SYNC_W-1:0]  pin_s;
  logic [LINK_SYNC_W-1:0] link_s;
  logic                   cs_s;
  logic                   hold_s;
  logic                   wp_s;
  logic                   tog_s;
  logic [BYTE_W-1:0]      byte_s;
  logic [BYTE_W-1:0]      op_s;
  logic                   seen_s;
  logic                   aligned_s;
  logic                   cs_rise;
  logic                   frame_ok;

  fpd_timer_if ent_t ();
  fpd_timer_if ext_t ();

  // Pins enter the core through two stages
  // They reset to idle high so no false frame end follows reset
  fpd_sync #(
    .W   (PIN_SYNC_W),
    .RST (PIN_IDLE)
  ) u_pin_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({cs_n_i, hold_n_i, wp_n_i}),
    .q_o      (pin_s)
  );

  // Link results are quasi-static once the frame or byte has ended
  // The toggle marks each finished byte, so no counter crosses domains
  fpd_sync #(
    .W   (LINK_SYNC_W),
    .RST ('0)
  ) u_link_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({lk_q.tog, lk_q.byte_q, lk_q.opcode,
                lk_q.op_seen, lk_q.aligned}),
    .q_o      (link_s)
  );

  assign {cs_s, hold_s, wp_s} = pin_s;
  assign {tog_s, byte_s, op_s, seen_s, aligned_s} = link_s;
  assign cs_rise = cs_s & ~q.cs_prev;
  // Link flags are stale until a byte of this frame has come through,
  // so a frame with no byte in it never acts on an older opcode
  assign frame_ok = seen_s & aligned_s & q.byte_in;

  // Entry and exit delays; loads are cut short by the frame-end latency
  // so that the whole delay from chip select stays inside the longest time
  fpd_timer #(
    .LOAD (TMR_W'(ENTRY_LOAD))
  ) u_entry_tmr (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .t        (ent_t.timer)
  );

  // Exit delay runs the same way as the entry delay
  fpd_timer #(
    .LOAD (TMR_W'(EXIT_LOAD))
  ) u_exit_tmr (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .t        (ext_t.timer)
  );

  // Power state, frame end decisions and status outputs
  always_comb begin
    d = q;
    d.rx_valid = 1'b0;
    d.abort = 1'b0;
    ent_t.start = 1'b0;
    ext_t.start = 1'b0;
    d.cs_prev = cs_s;
    d.tog_prev = tog_s;
    // A frame counts only if a byte finished since chip select fell
    if (!cs_s && q.cs_prev) begin
      d.byte_in = 1'b0;
    end
    if (tog_s != q.tog_prev) begin
      d.byte_in = 1'b1;
    end
    // Completed bytes go on only in standby
    if ((tog_s != q.tog_prev) && (q.pwr == PWR_STANDBY)) begin
      d.rx_byte = byte_s;
      d.rx_valid = 1'b1;
    end
    // Frames that end while a timer runs are dropped on purpose
    case (q.pwr)
      PWR_STANDBY: begin
        if (cs_rise && hold_s && frame_ok && (op_s == OP_POWER_DOWN)
            && !busy_i) begin
          d.pwr = PWR_ENTER;
          ent_t.start = 1'b1;
        end
      end
      PWR_ENTER: begin
        if (ent_t.done) begin
          d.pwr = PWR_DOWN;
        end
      end
      PWR_DOWN: begin
        if (cs_rise && hold_s && frame_ok
            && (op_s == OP_RESUME)) begin
          d.pwr = PWR_EXIT;
          ext_t.start = 1'b1;
        end
      end
      PWR_EXIT: begin
        if (ext_t.done) begin
          d.pwr = PWR_STANDBY;
        end
      end
      default: begin
        d.pwr = PWR_STANDBY;
      end
    endcase
    // Frame closed while paused aborts the operation
    if (cs_rise && !hold_s) begin
      d.abort = 1'b1;
    end
    // Enable latch: a set in the same cycle wins over any clear
    if (wel_clr_i || (cs_rise && !hold_s)) begin
      d.write_enable_latch = 1'b0;
    end
    if (wel_set_i) begin
      d.write_enable_latch = 1'b1;
    end
    // Protect input follows the pin even during a pause
    d.wprot = ~wp_s;
    // Output driven only in a live, unpaused standby frame
    d.so_oe = ~cs_s & hold_s & tx_en_i
              & (d.pwr == PWR_STANDBY);
    d.standby = (d.pwr == PWR_STANDBY);
    d.pd = (d.pwr == PWR_DOWN) || (d.pwr == PWR_EXIT);
  end

  // Core registers; reset lands in standby
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.pwr <= PWR_STANDBY;
      q.cs_prev <= 1'b1;
      q.standby <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Busy engine state is only read, never paused or cleared here
  assign so_oe_o = q.so_oe;
  assign rx_byte_o = q.rx_byte;
  assign rx_valid_o = q.rx_valid;
  assign frame_abort_o = q.abort;
  assign write_enable_latch_o = q.write_enable_latch;
  assign write_protect_o = q.wprot;
  assign standby_o = q.standby;
  assign power_down_o = q.pd;

endmodule
`default_nettype wire

// >>> fpd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the link: mode 0 clock that stands still between frames
module fpd_host_model (
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  output logic      hold_n_o,
  input  wire logic so_i
);
  logic [15:0] got;
  // Idle levels
  initial begin
    sck_o = 1'h0;
    cs_n_o = 1'h1;
    si_o = 1'h0;
    hold_n_o = 1'h1;
    got = 16'h0;
  end
  // One clock period
  task automatic tick();
    #40 sck_o = 1'h1;
    #40 sck_o = 1'h0;
  endtask
  // Frame of n bits, MSB first; pause before bit hb, abort when ab
  task automatic frame(input logic [15:0] d, input int n, input int hb,
                       input bit ab);
    cs_n_o = 1'h0;
    si_o = d[15];
    got = 16'h0;
    for (int i = 0; i < n; i++) begin
      if (i == hb) begin
        hold_n_o = 1'h0;
        si_o = ~si_o;
        repeat (4) tick();
        if (ab) begin
          cs_n_o = 1'h1;
          #400 hold_n_o = 1'h1;
          return;
        end
        hold_n_o = 1'h1;
        si_o = d[15-i];
      end
      #40 sck_o = 1'h1;
      #1 si_o = d[(14-i)&15];
      #39 got = {got[14:0], so_i};
      sck_o = 1'h0;
    end
    #40 cs_n_o = 1'h1;
    si_o = ~si_o; // Released line does not keep its value
    #400;
  endtask
endmodule
`default_nettype wire

// >>> fpd_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Checks on the core-clock side of the block
module fpd_ctrl_sva (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  input wire logic busy_i,
  input wire logic wel_set_i,
  input wire logic so_oe_o,
  input wire logic rx_valid_o,
  input wire logic frame_abort_o,
  input wire logic write_enable_latch_o,
  input wire logic write_protect_o,
  input wire logic standby_o,
  input wire logic power_down_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Entry into power-down in steps
  sequence s_enter_start;
    $fell(standby_o) && !power_down_o;
  endsequence
  sequence s_enter_done;
    ##[1:38] $rose(power_down_o);
  endsequence
  property p_enter_time; s_enter_start |-> s_enter_done; endproperty
  property p_exit_standby; $fell(power_down_o) |-> $rose(standby_o);
  endproperty
  property p_reset_standby; !$past(resetn_i) |-> standby_o && !power_down_o;
  endproperty
  property p_rx_standby; rx_valid_o |-> standby_o; endproperty
  property p_busy_keep; busy_i && standby_o |=> standby_o; endproperty
  property p_abort_wel;
    frame_abort_o && !wel_set_i |=> ##[0:1] !write_enable_latch_o;
  endproperty
  property p_wp_follow; $fell(wp_n_i) |-> ##[1:4] write_protect_o;
  endproperty
  property p_so_hold; (!hold_n_i && !cs_n_i)[*8] |-> !so_oe_o; endproperty
  a_enter_time: assert property (p_enter_time)
    else $error("power-down entry time wrong");
  a_exit_standby: assert property (p_exit_standby)
    else $error("exit did not return to standby");
  a_reset_standby: assert property (p_reset_standby)
    else $error("not in standby after reset");
  a_rx_standby: assert property (p_rx_standby)
    else $error("byte taken outside standby");
  a_busy_keep: assert property (p_busy_keep)
    else $error("left standby while busy");
  a_abort_wel: assert property (p_abort_wel)
    else $error("enable latch kept after abort");
  a_wp_follow: assert property (p_wp_follow)
    else $error("protect not followed");
  a_so_hold: assert property (p_so_hold)
    else $error("output driven while paused");
endmodule
bind fpd_ctrl fpd_ctrl_sva u_sva (
  .clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i),
  .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .busy_i(busy_i),
  .wel_set_i(wel_set_i), .so_oe_o(so_oe_o), .rx_valid_o(rx_valid_o),
  .frame_abort_o(frame_abort_o),
  .write_enable_latch_o(write_enable_latch_o),
  .write_protect_o(write_protect_o), .standby_o(standby_o),
  .power_down_o(power_down_o));
`default_nettype wire

// >>> fpd_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fpd_ctrl_bench
  import fpd_pkg::*;
;
  logic       clk_i, resetn_i, busy_i, wel_set_i, wp_n_i, tx_en_i;
  logic [7:0] tx_byte_i, rx_byte_o;
  logic [7:0] rx_last = 8'h00;
  logic       sck, cs_n, si, hold_n, so_o, so_oe_o, rx_valid_o;
  logic       ab_seen = 1'h0;
  logic       frame_abort_o, write_enable_latch_o, write_protect_o;
  logic       standby_o, power_down_o;
  int         bad_count, total_checks;
  int         rx_cnt = 0;

  fpd_ctrl uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n),
    .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i), .busy_i(busy_i),
    .wel_set_i(wel_set_i), .wel_clr_i(1'h0), .tx_byte_i(tx_byte_i),
    .tx_en_i(tx_en_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o),
    .frame_abort_o(frame_abort_o),
    .write_enable_latch_o(write_enable_latch_o),
    .write_protect_o(write_protect_o), .standby_o(standby_o),
    .power_down_o(power_down_o));
  fpd_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
    .hold_n_o(hold_n), .so_i(so_oe_o ? so_o : 1'bz));

  // Core clock
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Received bytes and abort pulses
  always @(posedge clk_i) begin
    if (rx_valid_o === 1'h1) begin
      rx_last <= rx_byte_o;
      rx_cnt <= rx_cnt + 1;
    end
    if (frame_abort_o === 1'h1) ab_seen <= 1'h1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Output timing, then a pause in mid-byte with protect toggled
  task automatic t_so_hold();
    tx_byte_i = 8'h96;
    host.frame(16'h05a5, 16, 99, 1'h0);
    chk(host.got[7:0], 8'h96);
    fork
      host.frame(16'h3c00, 8, 3, 1'h0);
      begin
        settle(12);
        wp_n_i = 1'h0;
        settle(6);
        chk(8'(write_protect_o), 8'h1);
        wp_n_i = 1'h1;
      end
    join
    settle(8);
    chk(rx_last, 8'h3c);
  endtask
  // Refused power-down frames
  task automatic t_bad_pd();
    host.frame(16'hb900, 7, 99, 1'h0);
    host.frame(16'hb900, 10, 99, 1'h0);
    settle(60);
    chk(8'(standby_o), 8'h1);
    busy_i = 1'h1;
    host.frame(16'hb900, 8, 99, 1'h0);
    settle(60);
    chk(8'(standby_o), 8'h1);
    busy_i = 1'h0;
  endtask
  // Entry, ignored commands, short resume, real resume
  task automatic t_pd();
    int n0;
    host.frame(16'hb9ff, 16, 99, 1'h0);
    settle(40);
    chk({standby_o, power_down_o}, 8'h1);
    n0 = rx_cnt;
    host.frame(16'h0500, 8, 99, 1'h0);
    settle(8);
    chk(8'(rx_cnt - n0), 8'h0);
    host.frame(16'hab00, 7, 99, 1'h0);
    settle(150);
    chk(8'(power_down_o), 8'h1);
    host.frame(16'hab5a, 16, 99, 1'h0);
    settle(130);
    chk({standby_o, power_down_o}, 8'h2);
  endtask
  // Chip select raised while paused
  task automatic t_abort();
    wel_set_i = 1'h1;
    settle(1);
    wel_set_i = 1'h0;
    settle(2);
    chk(8'(write_enable_latch_o), 8'h1);
    host.frame(16'h0600, 8, 2, 1'h1);
    settle(8);
    chk({ab_seen, write_enable_latch_o}, 8'h2);
    chk(8'(standby_o), 8'h1);
  endtask
  // Reset while powered down lands in standby
  task automatic t_reset();
    host.frame(16'hb900, 8, 99, 1'h0);
    settle(40);
    chk(8'(power_down_o), 8'h1);
    resetn_i = 1'h0;
    settle(3);
    resetn_i = 1'h1;
    settle(2);
    chk({standby_o, power_down_o}, 8'h2);
  endtask

  // Main sequence
  initial begin
    {busy_i, wel_set_i, bad_count, total_checks} = '0;
    {wp_n_i, tx_en_i} = 2'h3;
    tx_byte_i = 8'h00;
    resetn_i = 1'h0;
    host.tick();
    settle(3);
    resetn_i = 1'h1;
    settle(8);
    chk({standby_o, power_down_o}, 8'h2);
    t_so_hold();
    t_bad_pd();
    t_pd();
    t_abort();
    t_reset();
    test_done();
  end
  // Watchdog
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
